// file: design/shsp_pkg.sv
package shsp_pkg;

  // register image geometry
  localparam int SHSP_NUM_REGS = 64;
  localparam int SHSP_IDX_W = 6;

  // fixed bus address and the high-speed entry code
  localparam logic [6:0] SHSP_I2C_ADDR = 7'h20;
  localparam logic [4:0] SHSP_HS_CODE = 5'h01;

  // bit index of the last bit of a byte
  localparam logic [2:0] SHSP_BIT_LAST = 3'h7;

  // positions of the sampled pins in the synchroniser vector
  localparam int SHSP_PIN_CS = 0;
  localparam int SHSP_PIN_CLK = 1;
  localparam int SHSP_PIN_DAT = 2;
  localparam int SHSP_NUM_PINS = 3;

  // idle level of every sampled pin
  localparam logic [2:0] SHSP_PIN_IDLE = 3'h7;

  typedef enum logic [2:0] {
    SHSP_I_IDLE,
    SHSP_I_RX,
    SHSP_I_ACK,
    SHSP_I_TX,
    SHSP_I_RACK,
    SHSP_I_TXN
  } shsp_i2c_state_t;

  // synchronised pin view: level plus edge pulses
  typedef struct packed {
    logic [SHSP_NUM_PINS-1:0] lvl;
    logic [SHSP_NUM_PINS-1:0] rise;
    logic [SHSP_NUM_PINS-1:0] fall;
  } shsp_pins_t;

  // register write request toward the register file
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] data;
  } shsp_wreq_t;

  typedef struct packed {
    shsp_i2c_state_t ist;
    logic [2:0] ibit;
    logic [1:0] ibyte;
    logic [7:0] ish;
    logic [7:0] iidx;
    logic iack;
    logic ack_half;
    logic ito_tx;
    logic idrv;
    logic hs;
    logic locked;
    logic [2:0] sbit;
    logic sfirst;
    logic [7:0] ssh;
    logic [SHSP_IDX_W-1:0] sidx;
    logic sstep;
    logic srd;
    logic sdrv;
    logic [7:0] stx;
    logic [SHSP_NUM_REGS-1:0][7:0] snap;
    shsp_wreq_t wreq;
    logic serial_data_out;
    logic dat_o;
    logic dat_oe_b;
  } shsp_state_t;

  localparam shsp_state_t SHSP_STATE_RST = '{ist: SHSP_I_IDLE, sfirst: 1'b1, dat_oe_b: 1'b1, default: '0};

endpackage

// file: design/shsp_pin_sync.sv
`timescale 1ns/1ps
module shsp_pin_sync
  import shsp_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [SHSP_NUM_PINS-1:0] pins_in,
  output shsp_pins_t pins_out
);

  logic [SHSP_NUM_PINS-1:0] meta_reg;
  logic [SHSP_NUM_PINS-1:0] sync_reg;
  logic [SHSP_NUM_PINS-1:0] prev_reg;

  genvar g;
  generate
    for (g = 0; g < SHSP_NUM_PINS; g++) begin : g_pin
      // two-stage synchroniser, third stage only for edge finding
      always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
          meta_reg[g] <= SHSP_PIN_IDLE[g];
          sync_reg[g] <= SHSP_PIN_IDLE[g];
          prev_reg[g] <= SHSP_PIN_IDLE[g];
        end else begin
          meta_reg[g] <= pins_in[g];
          sync_reg[g] <= meta_reg[g];
          prev_reg[g] <= sync_reg[g];
        end
      end
      assign pins_out.lvl[g] = sync_reg[g];
      assign pins_out.rise[g] = sync_reg[g] & ~prev_reg[g];
      assign pins_out.fall[g] = ~sync_reg[g] & prev_reg[g];
    end
  endgenerate

endmodule

// file: design/shsp_port.sv
// Functional notes
// R1: chip select high keeps the two-wire port live and the four-wire port idle.
// R2: any chip select fall locks out two-wire until reset or software reset.
// R3: four-wire host should pulse chip select before other traffic.
// R4: two-wire slave answers only to fixed 7-bit address 0x20.
// R5: two-wire port covers fast and high-speed transfer classes.
// R6: only start, stop, acknowledge and 7-bit addressing are implemented.
// R7: first byte after address in a write is the starting register index.
// R8: acknowledge address byte 0x40; index acknowledged only when writable.
// R9: following write bytes go to consecutive registers until stop.
// R10: host reads by writing index, repeated start, then byte 0x41.
// R11: read returns consecutive registers while host acknowledges each byte.
// R12: code 00001xxx after start is not acknowledged and selects high bandwidth.
// R13: high-speed state holds until stop, then filters return to normal.
// R14: four wires, or three with the data-in line bidirectional.
// R15: chip select high with interrupts enabled puts interrupt on data-out.
// R16: interrupts disabled keeps data-out low except when returning read data.
// R17: host frames each four-wire transfer with chip select low.
// R18: clock may idle high or low; both work.
// R19: data changes on falling clock edge, sampled on rising edge.
// R20: single access takes 16 clocks; each further byte adds 8.
// R21: bit 0 begins at first falling clock edge after chip select falls.
// R22: first byte: six-bit index, address-step bit, direction bit, MSB first.
// R23: step bit 0 increments the index per byte; 1 keeps it fixed.
// R24: direction 1 drives read data from bit 8; 0 takes write data.
// R25: three-wire select enables bidirectional data-in operation.
// R26: register image is snapshotted at frame start; reads use the snapshot.
// R27: writes to non-writable registers are dropped but index still advances.
`timescale 1ns/1ps
module shsp_port
  import shsp_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic chip_select_low_in,
  input wire logic serial_clk_in,
  input wire logic serial_data_in_in,
  output logic serial_data_in_out,
  output logic serial_data_in_oe_b_out,
  output logic serial_data_out_out,
  input wire logic three_wire_select_in,
  input wire logic int_enable_in,
  input wire logic int_level_in,
  input wire logic soft_reset_in,
  input wire logic [SHSP_NUM_REGS-1:0][7:0] reg_image_in,
  input wire logic [SHSP_NUM_REGS-1:0] reg_writable_in,
  output logic reg_wr_out,
  output logic [7:0] reg_addr_out,
  output logic [7:0] reg_wdata_out,
  output logic hs_mode_out,
  output logic i2c_locked_out
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  shsp_pins_t pins;

  shsp_pin_sync u_sync (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .pins_in({serial_data_in_in, serial_clk_in, chip_select_low_in}),
    .pins_out(pins)
  );

  logic cs_lvl;
  logic cs_fall;
  logic clk_rise;
  logic clk_fall;
  logic dat_lvl;
  logic i2c_start;
  logic i2c_stop;

  assign cs_lvl = pins.lvl[SHSP_PIN_CS];
  assign cs_fall = pins.fall[SHSP_PIN_CS];
  assign clk_rise = pins.rise[SHSP_PIN_CLK];
  assign clk_fall = pins.fall[SHSP_PIN_CLK];
  assign dat_lvl = pins.lvl[SHSP_PIN_DAT];
  assign i2c_start = pins.fall[SHSP_PIN_DAT] & pins.lvl[SHSP_PIN_CLK] & ~clk_rise;
  assign i2c_stop = pins.rise[SHSP_PIN_DAT] & pins.lvl[SHSP_PIN_CLK] & ~clk_rise;

  ////////////////////////////////////////////////////////////////////////////
  // register image helpers

  function automatic logic [7:0] img_byte(input logic [7:0] idx,
                                          input logic [SHSP_NUM_REGS-1:0][7:0] img);
    logic [7:0] val;
    val = 8'h00;
    if (idx < 8'(SHSP_NUM_REGS)) begin
      val = img[idx[SHSP_IDX_W-1:0]];
    end
    return val;
  endfunction

  function automatic logic can_write(input logic [7:0] idx,
                                     input logic [SHSP_NUM_REGS-1:0] wmask);
    logic ok;
    ok = 1'b0;
    if (idx < 8'(SHSP_NUM_REGS)) begin
      ok = wmask[idx[SHSP_IDX_W-1:0]];
    end
    return ok;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  shsp_state_t r_reg;
  shsp_state_t r_next;

  logic i2c_on;
  logic [7:0] ibyte_in;
  logic [7:0] sbyte_in;
  logic [7:0] tx_now;

  // R1: two-wire live only with chip select high
  assign i2c_on = cs_lvl & ~r_reg.locked;
  assign ibyte_in = {r_reg.ish[6:0], dat_lvl};
  assign sbyte_in = {r_reg.ssh[6:0], dat_lvl};
  assign tx_now = img_byte(r_reg.iidx, reg_image_in);

  always_comb begin
    r_next = r_reg;
    r_next.wreq.wr = 1'b0;

    // R2: chip select fall locks; set beats a same-cycle clear
    if (cs_fall) begin
      r_next.locked = 1'b1;
    end else if (soft_reset_in) begin
      r_next.locked = 1'b0;
    end

    //////////////////////////////////////////////////////////////////////////
    // two-wire slave
    if (!i2c_on) begin
      r_next.ist = SHSP_I_IDLE;
      r_next.idrv = 1'b0;
      r_next.hs = 1'b0;
    end else if (i2c_start) begin
      r_next.ist = SHSP_I_RX;
      r_next.ibit = 3'h0;
      r_next.ibyte = 2'h0;
      r_next.idrv = 1'b0;
    end else if (i2c_stop) begin
      r_next.ist = SHSP_I_IDLE;
      r_next.idrv = 1'b0;
      // R13: stop returns filters to normal bandwidth
      r_next.hs = 1'b0;
    end else begin
      case (r_reg.ist)
        SHSP_I_IDLE: begin
          r_next.idrv = 1'b0;
        end
        SHSP_I_RX: begin
          if (clk_rise) begin
            r_next.ish = ibyte_in;
            r_next.ibit = r_reg.ibit + 3'h1;
            if (r_reg.ibit == SHSP_BIT_LAST) begin
              r_next.ist = SHSP_I_ACK;
              r_next.ack_half = 1'b0;
              r_next.ito_tx = 1'b0;
              case (r_reg.ibyte)
                2'h0: begin
                  if (ibyte_in[7:3] == SHSP_HS_CODE) begin
                    // R12: high-speed code is not acknowledged
                    r_next.hs = 1'b1;
                    r_next.ist = SHSP_I_IDLE;
                  end else if (ibyte_in[7:1] == SHSP_I2C_ADDR) begin
                    // R4: acknowledge own fixed address only
                    r_next.iack = 1'b1;
                    r_next.ito_tx = ibyte_in[0];
                    r_next.ibyte = 2'h1;
                  end else begin
                    // R6: no general call or other address forms
                    r_next.ist = SHSP_I_IDLE;
                  end
                end
                2'h1: begin
                  // R7: second byte is the register index
                  r_next.iidx = ibyte_in;
                  // R8: index acknowledged only when writable
                  r_next.iack = can_write(ibyte_in, reg_writable_in);
                  r_next.ibyte = 2'h2;
                end
                default: begin
                  r_next.iack = 1'b1;
                  // R27: unwritable target dropped silently
                  if (can_write(r_reg.iidx, reg_writable_in)) begin
                    r_next.wreq.wr = 1'b1;
                    r_next.wreq.addr = r_reg.iidx;
                    r_next.wreq.data = ibyte_in;
                  end
                  // R9: auto-increment per data byte
                  r_next.iidx = r_reg.iidx + 8'h01;
                end
              endcase
            end
          end
        end
        SHSP_I_ACK: begin
          if (clk_fall) begin
            if (!r_reg.ack_half) begin
              r_next.idrv = r_reg.iack;
              r_next.ack_half = 1'b1;
            end else if (r_reg.ito_tx) begin
              // R11: first read byte driven as ack ends
              r_next.ist = SHSP_I_TX;
              r_next.ibit = 3'h0;
              r_next.idrv = ~tx_now[7];
            end else begin
              r_next.ist = SHSP_I_RX;
              r_next.idrv = 1'b0;
            end
          end
        end
        SHSP_I_TX: begin
          if (clk_fall && r_reg.ibit != 3'h0) begin
            r_next.idrv = ~tx_now[SHSP_BIT_LAST - r_reg.ibit];
          end
          if (clk_rise) begin
            r_next.ibit = r_reg.ibit + 3'h1;
            if (r_reg.ibit == SHSP_BIT_LAST) begin
              r_next.ist = SHSP_I_RACK;
            end
          end
        end
        SHSP_I_RACK: begin
          if (clk_fall) begin
            r_next.idrv = 1'b0;
          end
          if (clk_rise) begin
            // R11: host ack continues with next register
            if (!dat_lvl) begin
              r_next.iidx = r_reg.iidx + 8'h01;
              r_next.ist = SHSP_I_TXN;
            end else begin
              r_next.ist = SHSP_I_IDLE;
            end
          end
        end
        SHSP_I_TXN: begin
          if (clk_fall) begin
            r_next.ist = SHSP_I_TX;
            r_next.ibit = 3'h0;
            r_next.idrv = ~tx_now[7];
          end
        end
        default: begin
          r_next.ist = SHSP_I_IDLE;
          r_next.idrv = 1'b0;
        end
      endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // four-wire slave
    if (cs_lvl) begin
      r_next.sbit = 3'h0;
      r_next.sfirst = 1'b1;
      r_next.srd = 1'b0;
      r_next.sdrv = 1'b0;
      r_next.stx = 8'h00;
    end else if (cs_fall) begin
      // R26: snapshot register image at frame start
      r_next.snap = reg_image_in;
    end else begin
      // R18 R19: sample on rise, either idle level
      if (clk_rise) begin
        r_next.ssh = sbyte_in;
        r_next.sbit = r_reg.sbit + 3'h1;
        // R20: every eighth rising edge closes a byte
        if (r_reg.sbit == SHSP_BIT_LAST) begin
          if (r_reg.sfirst) begin
            // R22: index, step bit, direction bit
            r_next.sidx = sbyte_in[7:2];
            r_next.sstep = sbyte_in[1];
            r_next.srd = sbyte_in[0];
            r_next.sfirst = 1'b0;
          end else begin
            // R24: direction 0 takes write data
            if (!r_reg.srd && can_write(8'(r_reg.sidx), reg_writable_in)) begin
              r_next.wreq.wr = 1'b1;
              r_next.wreq.addr = 8'(r_reg.sidx);
              r_next.wreq.data = sbyte_in;
            end
            // R23: step bit 0 increments, 1 holds
            if (!r_reg.sstep) begin
              r_next.sidx = r_reg.sidx + 6'h01;
            end
          end
        end
      end
      // R21: each bit launched on a falling edge
      if (clk_fall && r_reg.srd) begin
        r_next.sdrv = 1'b1;
        if (r_reg.sbit == 3'h0) begin
          r_next.stx = r_reg.snap[r_reg.sidx];
        end else begin
          r_next.stx = {r_reg.stx[6:0], 1'b0};
        end
      end
    end

    //////////////////////////////////////////////////////////////////////////
    // pin drivers
    if (cs_lvl) begin
      // R15: interrupt on data-out when enabled
      // R16: otherwise held low
      r_next.serial_data_out = int_enable_in & int_level_in;
    end else begin
      // R14: four-wire mode returns data on data-out
      r_next.serial_data_out = ~three_wire_select_in & r_next.sdrv & r_next.stx[7];
    end

    if (i2c_on) begin
      // open drain: only ever pull low
      r_next.dat_o = 1'b0;
      r_next.dat_oe_b = ~r_next.idrv;
    end else if (!cs_lvl && three_wire_select_in && r_next.sdrv) begin
      // R25: three-wire read data on the data-in line
      r_next.dat_o = r_next.stx[7];
      r_next.dat_oe_b = 1'b0;
    end else begin
      r_next.dat_o = 1'b0;
      r_next.dat_oe_b = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      r_reg <= SHSP_STATE_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign serial_data_in_out = r_reg.dat_o;
  assign serial_data_in_oe_b_out = r_reg.dat_oe_b;
  assign serial_data_out_out = r_reg.serial_data_out;
  assign reg_wr_out = r_reg.wreq.wr;
  assign reg_addr_out = r_reg.wreq.addr;
  assign reg_wdata_out = r_reg.wreq.data;
  // R5: high-speed flag steers the external input filters
  assign hs_mode_out = r_reg.hs;
  assign i2c_locked_out = r_reg.locked;

endmodule

// file: tb/shsp_checker.sv
`timescale 1ns/1ps
module shsp_checker (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic chip_select_low_in,
  input wire logic serial_clk_in,
  input wire logic serial_data_in_oe_b_out,
  input wire logic serial_data_out_out,
  input wire logic three_wire_select_in,
  input wire logic int_enable_in,
  input wire logic int_level_in,
  input wire logic soft_reset_in,
  input wire logic reg_wr_out,
  input wire logic [7:0] reg_addr_out,
  input wire logic hs_mode_out,
  input wire logic i2c_locked_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);
  sequence cs_idle;
    chip_select_low_in [*6];
  endsequence
  ////////////////////////////////////////
  lock_set_a: assert property ($fell(chip_select_low_in) |-> ##[1:5] i2c_locked_out)
    else $error("lockout not set");
  lock_hold_a: assert property (i2c_locked_out && !soft_reset_in |=> i2c_locked_out)
    else $error("lockout lost");
  lock_clear_a: assert property (cs_idle ##0 soft_reset_in |=> !i2c_locked_out)
    else $error("lockout not cleared");
  sdo_int_a: assert property (cs_idle |-> serial_data_out_out == $past(int_enable_in && int_level_in))
    else $error("data out not showing interrupt");
  hs_stop_a: assert property ($fell(hs_mode_out) && !i2c_locked_out |-> $past(serial_clk_in, 3))
    else $error("high speed left without stop");
  wr_pulse_a: assert property (reg_wr_out |=> !reg_wr_out)
    else $error("write pulse too long");
  addr_hold_a: assert property ($changed(reg_addr_out) |-> reg_wr_out)
    else $error("write index moved without write");
  spi4_oe_a: assert property ((!chip_select_low_in && !three_wire_select_in) [*4] |-> serial_data_in_oe_b_out)
    else $error("data in driven in four wire mode");
  sdo_three_a: assert property ((three_wire_select_in && !int_enable_in) [*6] |-> !serial_data_out_out)
    else $error("data out active in three wire mode");
  ack_edge_a: assert property ($changed(serial_data_in_oe_b_out) && chip_select_low_in && !i2c_locked_out
    |-> !$past(serial_clk_in, 3))
    else $error("two wire drive changed with clock high");
endmodule
bind shsp_port shsp_checker chk (
  .clk_in(clk_in), .rst_b_in(rst_b_in), .chip_select_low_in(chip_select_low_in),
  .serial_clk_in(serial_clk_in), .serial_data_in_oe_b_out(serial_data_in_oe_b_out),
  .serial_data_out_out(serial_data_out_out), .three_wire_select_in(three_wire_select_in),
  .int_enable_in(int_enable_in), .int_level_in(int_level_in), .soft_reset_in(soft_reset_in),
  .reg_wr_out(reg_wr_out), .reg_addr_out(reg_addr_out), .hs_mode_out(hs_mode_out),
  .i2c_locked_out(i2c_locked_out)
);

// file: tb/shsp_host_model.sv
`timescale 1ns/1ps
module shsp_host_model (
  input wire logic dut_dat_in,
  input wire logic dut_oe_b_in,
  input wire logic sdo_in,
  output logic chip_select_low_out,
  output logic serial_clk_out,
  output logic line_out
);
  logic mdat;
  logic men;
  logic m3;
  logic three;
  // pull-up line, any driver may pull low
  assign line_out = (dut_oe_b_in | dut_dat_in) & (!men | mdat);
  initial begin
    chip_select_low_out = 1'b1;
    serial_clk_out = 1'b1;
    mdat = 1'b1;
    men = 1'b1;
    m3 = 1'b1;
    three = 1'b0;
  end
  ////////////////////////////////////////
  // frame opens, clock idles per mode
  task automatic spi_begin(input logic mode3, input logic tw);
    m3 = mode3;
    three = tw;
    serial_clk_out = mode3;
    #160;
    chip_select_low_out = 1'b0;
    #160;
  endtask
  // change on fall, sample on rise
  task automatic spi_byte(input logic [7:0] tx, input logic drv, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      serial_clk_out = 1'b0;
      mdat = tx[i];
      men = drv;
      #160;
      serial_clk_out = 1'b1;
      rx[i] = three ? line_out : sdo_in;
      #160;
    end
  endtask
  task automatic spi_end();
    serial_clk_out = m3;
    #160;
    chip_select_low_out = 1'b1;
    mdat = ~mdat;
    men = 1'b1;
    #320;
  endtask
  task automatic i2c_start();
    mdat = 1'b1;
    men = 1'b1;
    #80;
    serial_clk_out = 1'b1;
    #160;
    mdat = 1'b0;
    #160;
    serial_clk_out = 1'b0;
    #80;
  endtask
  task automatic i2c_stop();
    mdat = 1'b0;
    #80;
    serial_clk_out = 1'b1;
    #160;
    mdat = 1'b1;
    #160;
  endtask
  // eight bits then the acknowledge bit
  task automatic i2c_byte(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      mdat = tx[i];
      #80;
      serial_clk_out = 1'b1;
      rx[i] = line_out;
      #160;
      serial_clk_out = 1'b0;
      #80;
    end
  endtask
endmodule

// file: tb/tb.sv
`timescale 1ns/1ps
module tb
  import shsp_pkg::*;
;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic cs, sclk, line, d_out, d_oe_b, serial_data_out, wr, hs, locked;
  logic tw = 1'b0;
  logic int_en = 1'b0;
  logic int_lvl = 1'b0;
  logic soft_rst = 1'b0;
  logic [7:0] waddr, wdata, b, d;
  logic [5:0] idx, ex;
  logic [8:0] r;
  logic [63:0] wmask;
  logic [SHSP_NUM_REGS-1:0][7:0] img, snap;
  logic [7:0] bad [5] = '{8'h42, 8'h00, 8'hf0, 8'h0d, 8'h08};
  logic [31:0] seed = 32'h819d_4ec3;
  logic [15:0] wq [$];
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #20 clk_in = ~clk_in;
  shsp_host_model host (.dut_dat_in(d_out), .dut_oe_b_in(d_oe_b), .sdo_in(serial_data_out),
    .chip_select_low_out(cs), .serial_clk_out(sclk), .line_out(line));
  shsp_port dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .chip_select_low_in(cs),
    .serial_clk_in(sclk), .serial_data_in_in(line), .serial_data_in_out(d_out),
    .serial_data_in_oe_b_out(d_oe_b), .serial_data_out_out(serial_data_out), .three_wire_select_in(tw),
    .int_enable_in(int_en), .int_level_in(int_lvl), .soft_reset_in(soft_rst),
    .reg_image_in(img), .reg_writable_in(wmask), .reg_wr_out(wr), .reg_addr_out(waddr),
    .reg_wdata_out(wdata), .hs_mode_out(hs), .i2c_locked_out(locked));
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (wr !== 1'b0) begin
      wq.push_back({waddr, wdata});
    end
    if (cyc == 20000) begin
      error_cnt++;
      conclude();
    end
  end
  ////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic rnd(output logic [7:0] v);
    seed = xs(seed);
    v = seed[7:0];
  endtask
  function automatic logic wok(input logic [7:0] i);
    return i < 8'h40 && wmask[i[5:0]];
  endfunction
  function automatic logic [7:0] ival(input logic [7:0] i);
    return (i < 8'h40) ? img[i[5:0]] : 8'h00;
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wchk(input logic [7:0] a, input logic [7:0] v, input logic ok);
    repeat (4) @(negedge clk_in);
    check(16'(wq.size()), ok);
    if (ok && wq.size() > 0) begin
      check(wq.pop_front(), {a, v});
    end
    wq.delete();
  endtask
  task automatic i2c_wr(input logic [7:0] i);
    host.i2c_start();
    host.i2c_byte({8'h40, 1'b1}, r);
    check(r[0], 1'b0);
    host.i2c_byte({i, 1'b1}, r);
    check(r[0], !wok(i));
    for (int k = 0; k < 2; k++) begin
      rnd(d);
      host.i2c_byte({d, 1'b1}, r);
      check(r[0], 1'b0);
      wchk(i + 8'(k), d, wok(i + 8'(k)));
    end
    host.i2c_stop();
  endtask
  task automatic i2c_rd(input logic [7:0] i);
    host.i2c_start();
    host.i2c_byte({8'h40, 1'b1}, r);
    host.i2c_byte({i, 1'b1}, r);
    host.i2c_start();
    host.i2c_byte({8'h41, 1'b1}, r);
    check(r[0], 1'b0);
    for (int k = 0; k < 3; k++) begin
      host.i2c_byte({8'hff, k == 2}, r);
      check(r[8:1], ival(i + 8'(k)));
    end
    host.i2c_stop();
  endtask
  task automatic conclude();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    for (int i = 0; i < 64; i++) begin
      rnd(img[i]);
      wmask[i] = seed[9];
    end
    repeat (16) @(negedge clk_in);
    rst_b_in = 1'b1;
    int_en = 1'b1;
    int_lvl = 1'b1;
    repeat (8) @(negedge clk_in);
    check({serial_data_out, locked}, 2'b10);
    for (int k = 0; k < 4; k++) begin
      rnd(b);
      i2c_wr({2'b00, b[5:0]});
      rnd(b);
      i2c_rd({2'b00, b[5:0]});
    end
    i2c_wr(8'h3f);
    i2c_rd(8'h3e);
    for (int j = 0; j < 5; j++) begin
      host.i2c_start();
      host.i2c_byte({bad[j], 1'b1}, r);
      check({r[0], hs}, {1'b1, bad[j][7:3] == SHSP_HS_CODE});
      host.i2c_start();
      host.i2c_byte({8'h40, 1'b1}, r);
      check({r[0], hs}, {1'b0, bad[j][7:3] == SHSP_HS_CODE});
      host.i2c_stop();
      repeat (8) @(negedge clk_in);
      check(hs, 1'b0);
    end
    for (int m = 0; m < 8; m++) begin
      @(negedge clk_in);
      tw = m[2] & (m[0] ^ m[1]);
      int_en = m[0];
      int_lvl = seed[3];
      rnd(b);
      idx = b[5:0];
      snap = img;
      repeat (8) @(negedge clk_in);
      host.spi_begin(m[0], tw);
      @(negedge clk_in);
      for (int i = 0; i < 64; i++) begin
        rnd(img[i]);
      end
      host.spi_byte({idx, m[1], m[2]}, 1'b1, b);
      for (int k = 0; k < 2; k++) begin
        rnd(d);
        host.spi_byte(d, !tw, b);
        ex = idx + (m[1] ? 6'h00 : 6'(k));
        if (m[2]) begin
          check(b, snap[ex]);
        end else begin
          wchk({2'b00, ex}, d, wmask[ex]);
        end
      end
      host.spi_end();
      check({locked, d_oe_b, serial_data_out}, {2'b11, int_en & int_lvl});
    end
    @(negedge clk_in);
    soft_rst = 1'b1;
    @(negedge clk_in);
    soft_rst = 1'b0;
    check(locked, 1'b0);
    i2c_wr(8'h05);
    conclude();
  end
endmodule
